// ---- hw/hk_adc_seq.sv ----
// housekeeping converter sequencer with avalon-mm register slave
`timescale 1ns/1ps
// Notes on behaviour
// - full power: single and background temperature
// - battery active: temperature single only
// - sleep: temperature background only
// - temperature result loads only on its interrupt
// - temperature interrupt: single done or over-delta
// - battery result is eight bits, own register
// - battery start bit 0, done when result loaded
// - programmed battery interval repeats conversions
// - battery below threshold sets low-battery flag
// - low-battery flag gated by enable bit 2
// - battery: full both, active single, sleep none
// - single battery sets flag; result loads then
// - supply result is eight bits, own register
// - supply start bit 2, interrupt on result
// - supply background off until interval written
// - supply over-delta in background sets flag 3
// - supply change flag gated by enable bit 3
// - supply gated by mode like temperature
// - supply result loads only on its interrupt
// - start bit clears when converter accepts
// - delta codes: 0 off, 1-6 counts, 7 every
module hk_adc_seq
    import hk_adc_pkg::*;
#(
    parameter int TICK_CYCLES = BASE_TICK_CYCLES
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_rstn,
    input  wire logic [7:0]        i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    output logic      [31:0]       o_avs_readdata,
    output logic                   o_avs_waitrequest,
    input  wire logic [2:0]        i_power_mode,
    output logic      [NUM_CH-1:0] o_conv_req,
    input  wire logic [NUM_CH-1:0] i_conv_ack,
    input  wire logic [NUM_CH-1:0] i_conv_done,
    input  wire logic [7:0]        i_battery_data,
    input  wire logic [7:0]        i_temp_data,
    input  wire logic [7:0]        i_supply_data,
    output logic                   o_temp_irq,
    output logic                   o_supply_irq,
    output logic                   o_power_irq
);

    // registers
    logic [7:0]        temperature_result_r;
    logic [7:0]        battery_result_r;
    logic [7:0]        supply_voltage_result_r;
    logic [NUM_CH-1:0] start_r;
    logic [7:0]        power_irq_enable_r;
    logic [7:0]        change_delta_config_r;
    logic [7:0]        background_interval_r;
    logic [7:0]        low_battery_threshold_r;
    logic              low_battery_flag_r;
    logic              supply_change_flag_r;

    // channel sequencing
    logic [NUM_CH-1:0] busy_r;
    logic [NUM_CH-1:0] single_r;
    logic [NUM_CH-1:0] bg_pend_r;
    logic [7:0]        temp_ref_r;
    logic [7:0]        supply_ref_r;

    // bus
    logic              wait_r;
    logic [31:0]       rdata_r;
    logic              wr_go;
    logic              wr_lane0;

    // strobes
    logic [31:0]       tick_cnt_r;
    logic              tick_r;
    logic [4:0]        strobe_cnt_r [NUM_CH];
    logic [NUM_CH-1:0] strobe;
    logic [1:0]        interval_code [NUM_CH];

    // mode gating
    logic [NUM_CH-1:0] single_ok;
    logic [NUM_CH-1:0] bg_ok;
    logic              is_full;
    logic              is_active;
    logic              is_sleep;

    // completion decode
    logic              temp_pub;
    logic              supply_over;
    logic              supply_pub;
    logic              batt_flag_set;

    function automatic logic over_delta(input logic [7:0] new_v,
                                        input logic [7:0] ref_v,
                                        input logic [2:0] code);
        logic [7:0] diff;
        // magnitude first so a wrap never fakes a step
        diff = (new_v > ref_v) ? 8'(new_v - ref_v) : 8'(ref_v - new_v);
        if (code == DELTA_OFF) begin
            over_delta = 1'b0;
        end else if (code == DELTA_EVERY) begin
            over_delta = 1'b1;
        end else begin
            over_delta = diff > {5'h00, code};
        end
    endfunction

    // interval code n gives a period of 4^(n-1) base ticks
    function automatic logic [4:0] period_ticks(input logic [1:0] code);
        case (code)
            2'h1:    period_ticks = 5'h01;
            2'h2:    period_ticks = 5'h04;
            2'h3:    period_ticks = 5'h10;
            default: period_ticks = 5'h00;
        endcase
    endfunction

    assign is_full   = (i_power_mode == full_power_mode);
    assign is_active = (i_power_mode == battery_active_mode);
    assign is_sleep  = (i_power_mode == sleep_mode);
    // an illegal mode code blocks every start

    always_comb begin
        single_ok[CH_TEMP]    = is_full | is_active;
        bg_ok[CH_TEMP]        = is_full | is_sleep;
        single_ok[CH_BATTERY] = is_full | is_active;
        bg_ok[CH_BATTERY]     = is_full;
        single_ok[CH_SUPPLY]  = is_full | is_active;
        bg_ok[CH_SUPPLY]      = is_full | is_sleep;
    end

    assign interval_code[CH_BATTERY] = background_interval_r[BATTERY_INTERVAL_LSB +: INTERVAL_W];
    assign interval_code[CH_TEMP]    = background_interval_r[TEMP_INTERVAL_LSB +: INTERVAL_W];
    assign interval_code[CH_SUPPLY]  = background_interval_r[SUPPLY_INTERVAL_LSB +: INTERVAL_W];

    // ---------------- avalon-mm slave: one wait state per access
    // wait state lets read data come from a flip-flop
    assign wr_go    = i_avs_write & ~wait_r;
    assign wr_lane0 = wr_go & i_avs_byteenable[0];

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            wait_r <= 1'b1;
        end else if ((i_avs_read | i_avs_write) & wait_r) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            rdata_r <= 32'h0000_0000;
        end else if (i_avs_read & wait_r) begin
            case (i_avs_address)
                IDX_TEMPERATURE_RESULT:    rdata_r <= {24'h00_0000, temperature_result_r};
                IDX_CONVERSION_START:      rdata_r <= {29'h0000_0000, start_r};
                IDX_BATTERY_RESULT:        rdata_r <= {24'h00_0000, battery_result_r};
                IDX_POWER_IRQ_ENABLE:      rdata_r <= {24'h00_0000, power_irq_enable_r};
                IDX_SUPPLY_VOLTAGE_RESULT: rdata_r <= {24'h00_0000, supply_voltage_result_r};
                IDX_CHANGE_DELTA_CONFIG:   rdata_r <= {24'h00_0000, change_delta_config_r};
                IDX_POWER_IRQ_FLAGS: begin
                    rdata_r <= 32'h0000_0000;
                    rdata_r[LOW_BATTERY_BIT]   <= low_battery_flag_r;
                    rdata_r[SUPPLY_CHANGE_BIT] <= supply_change_flag_r;
                end
                IDX_BACKGROUND_INTERVAL:   rdata_r <= {24'h00_0000, background_interval_r};
                IDX_LOW_BATTERY_THRESHOLD: rdata_r <= {24'h00_0000, low_battery_threshold_r};
                default:                   rdata_r <= {24'h00_0000, READ_ZERO};
            endcase
        end
    end

    assign o_avs_waitrequest = wait_r;
    assign o_avs_readdata    = rdata_r;

    // plain configuration registers
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            power_irq_enable_r      <= RST_CONFIG;
            change_delta_config_r   <= RST_CONFIG;
            background_interval_r   <= RST_CONFIG;
            low_battery_threshold_r <= RST_THRESHOLD;
        end else if (wr_lane0) begin
            case (i_avs_address)
                IDX_POWER_IRQ_ENABLE:      power_irq_enable_r      <= i_avs_writedata[7:0];
                IDX_CHANGE_DELTA_CONFIG:   change_delta_config_r   <= i_avs_writedata[7:0];
                IDX_BACKGROUND_INTERVAL:   background_interval_r   <= i_avs_writedata[7:0];
                IDX_LOW_BATTERY_THRESHOLD: low_battery_threshold_r <= i_avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // ---------------- background strobes
    // one divider keeps all strobes aligned
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
            tick_r     <= 1'b0;
        end
    end

    // counters restart whenever their interval is off, so a fresh setting
    // counts its whole period in ticks of the free-running divider before its first conversion
    always_ff @(posedge i_core_clk) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (!i_rstn || interval_code[c] == 2'h0) begin
                strobe_cnt_r[c] <= 5'h00;
            end else if (tick_r) begin
                if (strobe_cnt_r[c] >= 5'(period_ticks(interval_code[c]) - 5'h01)) begin
                    strobe_cnt_r[c] <= 5'h00;
                end else begin
                    strobe_cnt_r[c] <= strobe_cnt_r[c] + 5'h01;
                end
            end
        end
    end

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            strobe[c] = tick_r && interval_code[c] != 2'h0 &&
                        strobe_cnt_r[c] >= 5'(period_ticks(interval_code[c]) - 5'h01);
        end
    end

    // ---------------- start bits and converter handshake
    // a single-conversion ack beats a software set in the same cycle
    always_ff @(posedge i_core_clk) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (!i_rstn) begin
                start_r[c] <= 1'b0;
            end else if (o_conv_req[c] && i_conv_ack[c] && single_r[c]) begin
                start_r[c] <= 1'b0;
            end else if (wr_lane0 && i_avs_address == IDX_CONVERSION_START &&
                         i_avs_writedata[c]) begin
                start_r[c] <= 1'b1;
            end
        end
    end

    // a start bit waits while its mode forbids single conversions
    always_ff @(posedge i_core_clk) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (!i_rstn) begin
                o_conv_req[c] <= 1'b0;
                single_r[c]   <= 1'b0;
                busy_r[c]     <= 1'b0;
                bg_pend_r[c]  <= 1'b0;
            end else begin
                // interval off drops a waiting strobe
                if (interval_code[c] == 2'h0) begin
                    bg_pend_r[c] <= 1'b0;
                end else if (strobe[c] && bg_ok[c]) begin
                    bg_pend_r[c] <= 1'b1;
                end
                if (o_conv_req[c]) begin
                    if (i_conv_ack[c]) begin
                        o_conv_req[c] <= 1'b0;
                        busy_r[c]     <= 1'b1;
                    end
                end else if (busy_r[c]) begin
                    if (i_conv_done[c]) begin
                        busy_r[c] <= 1'b0;
                    end
                end else if (start_r[c] && single_ok[c]) begin
                    o_conv_req[c] <= 1'b1;
                    single_r[c]   <= 1'b1;
                end else if (bg_pend_r[c] && bg_ok[c]) begin
                    o_conv_req[c] <= 1'b1;
                    single_r[c]   <= 1'b0;
                    bg_pend_r[c]  <= strobe[c];
                end
            end
        end
    end

    // ---------------- result handling
    assign temp_pub = busy_r[CH_TEMP] && i_conv_done[CH_TEMP] &&
                      (single_r[CH_TEMP] ||
                       over_delta(i_temp_data, temp_ref_r,
                                  change_delta_config_r[TEMP_DELTA_LSB +: DELTA_W]));
    assign supply_over = busy_r[CH_SUPPLY] && i_conv_done[CH_SUPPLY] &&
                         !single_r[CH_SUPPLY] &&
                         over_delta(i_supply_data, supply_ref_r,
                                    change_delta_config_r[SUPPLY_DELTA_LSB +: DELTA_W]);
    assign supply_pub  = supply_over ||
                         (busy_r[CH_SUPPLY] && i_conv_done[CH_SUPPLY] && single_r[CH_SUPPLY]);
    // a single conversion publishes above threshold too
    assign batt_flag_set = busy_r[CH_BATTERY] && i_conv_done[CH_BATTERY] &&
                           (single_r[CH_BATTERY] ||
                            i_battery_data < low_battery_threshold_r);

    // reference follows each published value
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            temperature_result_r <= RST_RESULT;
            temp_ref_r           <= RST_RESULT;
            o_temp_irq           <= 1'b0;
        end else begin
            o_temp_irq <= temp_pub;
            if (temp_pub) begin
                temperature_result_r <= i_temp_data;
                temp_ref_r           <= i_temp_data;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            supply_voltage_result_r <= RST_RESULT;
            supply_ref_r            <= RST_RESULT;
            o_supply_irq            <= 1'b0;
        end else begin
            o_supply_irq <= supply_pub;
            if (supply_pub) begin
                supply_voltage_result_r <= i_supply_data;
                supply_ref_r            <= i_supply_data;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            battery_result_r <= RST_RESULT;
        end else if (batt_flag_set) begin
            battery_result_r <= i_battery_data;
        end
    end

    // flags clear by writing one; a set in the same cycle wins
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            low_battery_flag_r   <= 1'b0;
            supply_change_flag_r <= 1'b0;
        end else begin
            if (batt_flag_set) begin
                low_battery_flag_r <= 1'b1;
            end else if (wr_lane0 && i_avs_address == IDX_POWER_IRQ_FLAGS &&
                         i_avs_writedata[LOW_BATTERY_BIT]) begin
                low_battery_flag_r <= 1'b0;
            end
            if (supply_over) begin
                supply_change_flag_r <= 1'b1;
            end else if (wr_lane0 && i_avs_address == IDX_POWER_IRQ_FLAGS &&
                         i_avs_writedata[SUPPLY_CHANGE_BIT]) begin
                supply_change_flag_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_power_irq <= 1'b0;
        end else begin
            o_power_irq <= (low_battery_flag_r & power_irq_enable_r[LOW_BATTERY_BIT]) |
                           (supply_change_flag_r & power_irq_enable_r[SUPPLY_CHANGE_BIT]);
        end
    end

endmodule

// ---- hw/hk_adc_pkg.sv ----
// shared constants for the housekeeping converter sequencer
package hk_adc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_TEMPERATURE_RESULT    = 8'hD7;
    localparam logic [7:0] IDX_CONVERSION_START      = 8'hD8;
    localparam logic [7:0] IDX_BATTERY_RESULT        = 8'hDF;
    localparam logic [7:0] IDX_POWER_IRQ_ENABLE      = 8'hEC;
    localparam logic [7:0] IDX_SUPPLY_VOLTAGE_RESULT = 8'hEF;
    localparam logic [7:0] IDX_CHANGE_DELTA_CONFIG   = 8'hF3;
    localparam logic [7:0] IDX_POWER_IRQ_FLAGS       = 8'hF8;
    localparam logic [7:0] IDX_BACKGROUND_INTERVAL   = 8'hF9;
    localparam logic [7:0] IDX_LOW_BATTERY_THRESHOLD = 8'hFA;

    // channel numbers double as start-bit positions
    localparam int CH_BATTERY = 0;
    localparam int CH_TEMP    = 1;
    localparam int CH_SUPPLY  = 2;
    localparam int NUM_CH     = 3;

    // power_irq_flags / power_irq_enable bit positions
    localparam int LOW_BATTERY_BIT   = 2;
    localparam int SUPPLY_CHANGE_BIT = 3;

    // change_delta_config fields
    localparam int SUPPLY_DELTA_LSB = 0;
    localparam int TEMP_DELTA_LSB   = 3;
    localparam int DELTA_W          = 3;
    localparam logic [2:0] DELTA_OFF   = 3'h0;
    localparam logic [2:0] DELTA_EVERY = 3'h7;

    // background_interval fields, two bits per channel, code 0 is off
    localparam int BATTERY_INTERVAL_LSB = 0;
    localparam int TEMP_INTERVAL_LSB    = 2;
    localparam int SUPPLY_INTERVAL_LSB  = 4;
    localparam int INTERVAL_W           = 2;

    // reset values
    localparam logic [7:0] RST_RESULT    = 8'h00;
    localparam logic [7:0] RST_CONFIG    = 8'h00;
    localparam logic [7:0] RST_THRESHOLD = 8'h00;
    localparam logic [7:0] READ_ZERO     = 8'h00;

    // base tick of the background strobes
    localparam int CLK_MHZ         = 100;
    localparam int BASE_TICK_US    = 1000;
    localparam int BASE_TICK_CYCLES = BASE_TICK_US * CLK_MHZ;

    typedef enum logic [2:0] {
        full_power_mode     = 3'b001,
        battery_active_mode = 3'b010,
        sleep_mode          = 3'b100
    } power_mode_t;
endpackage

// ---- verification/hk_adc_seq_assertions.sv ----
// port-level concurrent checks for the converter sequencer
`timescale 1ns/1ps
module hk_adc_seq_chk
    import hk_adc_pkg::*;
#(
    parameter int TICK_CYCLES = BASE_TICK_CYCLES
) (
    input wire logic              i_core_clk,
    input wire logic              i_rstn,
    input wire logic              i_avs_read,
    input wire logic              i_avs_write,
    input wire logic [31:0]       o_avs_readdata,
    input wire logic              o_avs_waitrequest,
    input wire logic [2:0]        i_power_mode,
    input wire logic [NUM_CH-1:0] o_conv_req,
    input wire logic [NUM_CH-1:0] i_conv_ack,
    input wire logic [NUM_CH-1:0] i_conv_done,
    input wire logic              o_temp_irq,
    input wire logic              o_supply_irq
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    property p_one_wait;
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("no answer after one wait");
    property p_wait_pulse;
        !o_avs_waitrequest |=> o_avs_waitrequest;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse) else $error("answer longer than one cycle");
    property p_read_hi;
        !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0;
    endproperty
    a_read_hi: assert property (p_read_hi) else $error("upper read bits not zero");
    property p_req_hold;
        o_conv_req[CH_TEMP] && !i_conv_ack[CH_TEMP] |=> o_conv_req[CH_TEMP];
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped before ack");
    property p_req_drop;
        (o_conv_req & i_conv_ack) != 3'h0 |=> (o_conv_req & $past(i_conv_ack)) == 3'h0;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("request held after ack");
    property p_temp_src;
        $rose(o_temp_irq) |-> $past(i_conv_done[CH_TEMP]);
    endproperty
    a_temp_src: assert property (p_temp_src) else $error("temp irq without done");
    property p_temp_pulse;
        o_temp_irq |=> !o_temp_irq;
    endproperty
    a_temp_pulse: assert property (p_temp_pulse) else $error("temp irq not a pulse");
    property p_supply_src;
        $rose(o_supply_irq) |-> $past(i_conv_done[CH_SUPPLY]);
    endproperty
    a_supply_src: assert property (p_supply_src) else $error("supply irq without done");
    property p_sleep_batt;
        $rose(o_conv_req[CH_BATTERY]) |-> $past(i_power_mode) != sleep_mode;
    endproperty
    a_sleep_batt: assert property (p_sleep_batt) else $error("battery request in sleep");
endmodule

bind hk_adc_seq hk_adc_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_power_mode(i_power_mode),
    .o_conv_req(o_conv_req), .i_conv_ack(i_conv_ack), .i_conv_done(i_conv_done),
    .o_temp_irq(o_temp_irq), .o_supply_irq(o_supply_irq));

// ---- verification/test_hk_adc_seq.sv ----
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module test_hk_adc_seq
    import hk_adc_pkg::*;
;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    logic        i_core_clk;
    logic        i_rstn = 1'b0;
    logic [7:0]  av_addr = 8'h0;
    logic        av_rd = 1'b0;
    logic        av_wr = 1'b0;
    logic [31:0] av_wd = 32'h0;
    logic [31:0] readdata;
    logic        waitreq;
    logic [2:0]  mode = full_power_mode;
    logic [2:0]  conv_req;
    logic [2:0]  ack = 3'h0;
    logic [2:0]  done = 3'h0;
    logic [7:0]  bat_d = 8'h0;
    logic [7:0]  tmp_d = 8'h0;
    logic [7:0]  sup_d = 8'h0;
    logic        temp_irq;
    logic        sup_irq;
    logic        pwr_irq;
    logic [7:0]  rd;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          tmp_n = 0;
    int          sup_n = 0;
    int          bat_n = 0;
    int          pwr_n = 0;
    int          n0;
    int          cnt [3] = '{0, 0, 0};
    row_t        rows [10] = '{'{8'hD7, 8'h55, 8'h00}, '{8'hD8, 8'h00, 8'h00},
        '{8'hDF, 8'h55, 8'h00}, '{8'hEF, 8'h55, 8'h00}, '{8'hEC, 8'h0C, 8'h0C},
        '{8'hF3, 8'h09, 8'h09}, '{8'hFA, 8'hA5, 8'hA5}, '{8'hF9, 8'h00, 8'h00},
        '{8'hF8, 8'h0C, 8'h00}, '{8'hE0, 8'hFF, 8'h00}};

    hk_adc_seq #(.TICK_CYCLES(4)) DUT (
        .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_avs_address(av_addr),
        .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wd),
        .i_avs_byteenable(4'hF), .o_avs_readdata(readdata), .o_avs_waitrequest(waitreq),
        .i_power_mode(mode), .o_conv_req(conv_req), .i_conv_ack(ack), .i_conv_done(done),
        .i_battery_data(bat_d), .i_temp_data(tmp_d), .i_supply_data(sup_d),
        .o_temp_irq(temp_irq), .o_supply_irq(sup_irq), .o_power_irq(pwr_irq));

    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end

    // converter stand-in: ack one cycle after request, done a few cycles later
    always @(posedge i_core_clk) begin
        for (int c = 0; c < 3; c++) begin
            ack[c] <= conv_req[c] && cnt[c] == 0 && !ack[c];
            done[c] <= cnt[c] == 1;
            if (conv_req[c] && cnt[c] == 0 && !ack[c]) cnt[c] <= 3 + c;
            else if (cnt[c] > 0) cnt[c] <= cnt[c] - 1;
        end
        tmp_n <= tmp_n + (temp_irq === 1'b1);
        sup_n <= sup_n + (sup_irq === 1'b1);
        bat_n <= bat_n + (conv_req[0] && ack[0]);
        pwr_n <= pwr_n + (pwr_irq === 1'b1);
    end

    task automatic final_report();
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s: got %h exp %h", $time, m, got, exp);
        end
    endtask

    // request held until the edge that sees waitrequest low
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge i_core_clk);
        av_addr <= a;
        av_wd <= {24'h0, d};
        av_wr <= w;
        av_rd <= !w;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        if (waitreq !== 1'b0) begin num_errors++; final_report(); end
        rd = readdata[7:0];
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string m);
        bus(1'b0, a, 8'h0);
        check(rd, e, m);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask

    task automatic wait_cnt(ref int v, input int tgt);
        int n;
        n = 0;
        while (v < tgt && n < 2000) begin @(posedge i_core_clk); n++; end
        if (v < tgt) begin num_errors++; final_report(); end
    endtask

    // polls a register until one of the mask bits shows
    task automatic poll(input logic [7:0] a, input logic [7:0] m);
        int n;
        n = 0;
        do begin bus(1'b0, a, 8'h0); n++; end while ((rd & m) == 8'h0 && n < 40);
        if ((rd & m) == 8'h0) begin num_errors++; final_report(); end
    endtask

    initial begin
        cyc(10);
        i_rstn <= 1'b1;
        foreach (rows[i]) begin
            rchk(rows[i].a, RST_RESULT, "reset value");
            bus(1'b1, rows[i].a, rows[i].d);
            rchk(rows[i].a, rows[i].e, "register access");
        end
        $display("register table done");
        tmp_d <= 8'h3C;
        bus(1'b1, IDX_CONVERSION_START, 8'h02);
        wait_cnt(tmp_n, 1);
        rchk(IDX_TEMPERATURE_RESULT, 8'h3C, "temp single");
        rchk(IDX_CONVERSION_START, 8'h00, "start cleared");
        $display("temp single done");
        mode <= battery_active_mode;
        bat_d <= 8'hC8;
        bus(1'b1, IDX_CONVERSION_START, 8'h01);
        wait_cnt(pwr_n, 1);
        rchk(IDX_BATTERY_RESULT, 8'hC8, "battery single");
        rchk(IDX_POWER_IRQ_FLAGS, 8'h04, "flag on single");
        check(pwr_irq, 1'b1, "power irq");
        bus(1'b1, IDX_POWER_IRQ_FLAGS, 8'h04);
        rchk(IDX_POWER_IRQ_FLAGS, 8'h00, "flag clear");
        check(pwr_irq, 1'b0, "power irq clear");
        $display("battery single done");
        mode <= full_power_mode;
        bus(1'b1, IDX_POWER_IRQ_ENABLE, 8'h08);
        bat_d <= 8'h10;
        bus(1'b1, IDX_CONVERSION_START, 8'h01);
        poll(IDX_POWER_IRQ_FLAGS, 8'h04);
        check(rd, 8'h04, "low battery flag");
        check(pwr_irq, 1'b0, "masked power irq");
        rchk(IDX_BATTERY_RESULT, 8'h10, "battery low value");
        mode <= sleep_mode;
        bus(1'b1, IDX_CONVERSION_START, 8'h01);
        cyc(30);
        check(bat_n, 2, "no battery in sleep");
        rchk(IDX_CONVERSION_START, 8'h01, "start waits");
        mode <= full_power_mode;
        wait_cnt(bat_n, 3);
        rchk(IDX_CONVERSION_START, 8'h00, "start cleared late");
        cyc(20);
        bus(1'b1, IDX_POWER_IRQ_FLAGS, 8'h0C);
        $display("battery gating done");
        mode <= sleep_mode;
        sup_d <= 8'h01;
        bus(1'b1, IDX_BACKGROUND_INTERVAL, 8'h10);
        cyc(40);
        check(sup_n, 0, "delta not exceeded");
        rchk(IDX_SUPPLY_VOLTAGE_RESULT, 8'h00, "supply result kept");
        sup_d <= 8'h02;
        wait_cnt(sup_n, 1);
        rchk(IDX_SUPPLY_VOLTAGE_RESULT, 8'h02, "supply published");
        rchk(IDX_POWER_IRQ_FLAGS, 8'h08, "supply flag");
        check(pwr_irq, 1'b1, "supply power irq");
        cyc(40);
        check(sup_n, 1, "reference reloaded");
        bus(1'b1, IDX_CHANGE_DELTA_CONFIG, 8'h0F);
        wait_cnt(sup_n, 3);
        bus(1'b1, IDX_CHANGE_DELTA_CONFIG, 8'h08);
        sup_d <= 8'h60;
        cyc(10);
        n0 = sup_n;
        cyc(40);
        check(sup_n, n0, "delta code off");
        tmp_d <= 8'h44;
        sup_d <= 8'h7E;
        bus(1'b1, IDX_CONVERSION_START, 8'h06);
        cyc(30);
        rchk(IDX_CONVERSION_START, 8'h06, "sleep singles wait");
        mode <= full_power_mode;
        wait_cnt(sup_n, n0 + 1);
        rchk(IDX_SUPPLY_VOLTAGE_RESULT, 8'h7E, "supply single");
        rchk(IDX_TEMPERATURE_RESULT, 8'h44, "temp single");
        $display("supply background done");
        bus(1'b1, IDX_CHANGE_DELTA_CONFIG, 8'h38);
        bus(1'b1, IDX_BACKGROUND_INTERVAL, 8'h05);
        mode <= battery_active_mode;
        cyc(10);
        n0 = tmp_n;
        cyc(40);
        check(tmp_n, n0, "no temp background");
        mode <= sleep_mode;
        n0 = bat_n;
        wait_cnt(tmp_n, tmp_n + 2);
        check(bat_n, n0, "no battery background");
        mode <= full_power_mode;
        wait_cnt(bat_n, n0 + 2);
        poll(IDX_POWER_IRQ_FLAGS, 8'h04);
        check(rd & 8'h04, 8'h04, "background low flag");
        wait_cnt(tmp_n, tmp_n + 1);
        $display("background gating done");
        i_rstn <= 1'b0;
        cyc(10);
        i_rstn <= 1'b1;
        rchk(IDX_BACKGROUND_INTERVAL, RST_CONFIG, "interval after reset");
        rchk(IDX_TEMPERATURE_RESULT, RST_RESULT, "result after reset");
        $display("second reset done");
        final_report();
    end
endmodule
